// [hdl/spllc_consts.svh]
// Register offsets, field positions, reset values and timing figures of the PLL control block.
`ifndef SPLLC_CONSTS_SVH
`define SPLLC_CONSTS_SVH

// ==================================================================
// Register byte addresses
`define SPLLC_ADDR_CTRL 16'h0100
`define SPLLC_ADDR_CFG 16'h0101
`define SPLLC_ADDR_FBDIV 16'h0102
`define SPLLC_ADDR_PERIOD0 16'h0103
`define SPLLC_ADDR_PERIOD1 16'h0104
`define SPLLC_ADDR_PERIOD2 16'h0105
`define SPLLC_ADDR_TIMER0 16'h0106
`define SPLLC_ADDR_TIMER1 16'h0107
`define SPLLC_ADDR_TIMER2 16'h0108
`define SPLLC_ADDR_MASK 16'h0109
`define SPLLC_ADDR_CAL 16'h0a02
`define SPLLC_ADDR_STATUS 16'h0d01
`define SPLLC_ADDR_MONITOR 16'h0d02

// ==================================================================
// Field positions
`define SPLLC_CTRL_EXT_FILTER 7
`define SPLLC_CTRL_CP_MANUAL 6
`define SPLLC_CTRL_CP_HI 5
`define SPLLC_CTRL_CP_LO 3
`define SPLLC_CTRL_LD_DISABLE 2
`define SPLLC_CFG_PLL_ENABLE 0
`define SPLLC_CAL_START 0
`define SPLLC_STAT_LOCKED 0
`define SPLLC_STAT_CAL_BUSY 1
`define SPLLC_STAT_STABLE 4

// ==================================================================
// Reset values
`define SPLLC_CTRL_RESET 8'h18
`define SPLLC_CFG_RESET 8'h00
`define SPLLC_FBDIV_RESET 8'h28
`define SPLLC_PERIOD_RESET 21'h0f4240
`define SPLLC_TIMER_RESET 20'h00000
`define SPLLC_MASK_RESET 8'h00

// ==================================================================
// Limits and timing
`define SPLLC_FBDIV_MIN 8'h06
`define SPLLC_LOCK_BASE 11'h080
`define SPLLC_MS_NS 1000000
`define SPLLC_CLK_NS 25

`endif

// [hdl/spllc_pkg.sv]
// Types shared by the PLL control block.
package spllc_pkg;

    // Stability timer states.
    typedef enum logic [1:0]
    {
        SPLLC_ST_WAIT_LOCK = 2'b00,
        SPLLC_ST_COUNT = 2'b01,
        SPLLC_ST_STABLE = 2'b10
    } spllc_timer_state_t;

endpackage : spllc_pkg

// [hdl/spllc_sync.sv]
// Two flip-flop synchroniser for a group of independent pin levels.
`timescale 1ns/1ps

module spllc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // The first stage feeds only the second, so metastability settles before use.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule : spllc_sync

// [hdl/spllc_top.sv]
// System clock multiplier PLL control: lock detector, charge pump, dividers, timer and calibration.
`timescale 1ns/1ps
`include "spllc_consts.svh"

module spllc_top
    import spllc_pkg::*;
#(
    parameter int MS_CYCLES = `SPLLC_MS_NS / `SPLLC_CLK_NS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Phase detector and VCO calibration pins
    input wire logic pfd_sample_toggle,
    input wire logic pfd_in_phase,
    input wire logic vco_cal_done,
    output logic vco_cal_start,
    // Analog settings
    output logic pll_enable,
    output logic [1:0] input_div_sel,
    output logic [7:0] feedback_div,
    output logic [2:0] cp_current_code,
    output logic ext_filter_sel,
    output logic [20:0] clock_period_fs,
    // Status outputs
    output logic pll_locked,
    output logic clock_stable,
    output logic ref_monitor_enable,
    output logic irq_out
);

    localparam int MSW = $clog2(MS_CYCLES + 1);

    // ==================================================================
    // Registers
    logic [7:0] ctrl_reg;
    logic [7:0] cfg_reg;
    logic [7:0] fbdiv_reg;
    logic [20:0] period_reg;
    logic [19:0] timer_val_reg;
    logic [7:0] mask_reg;
    logic cal_bit_reg;
    logic cal_busy_reg;
    logic [7:0] monitor_reg;
    logic [7:0] rdata_reg;
    logic cal_start_reg;
    logic tick_prev_reg;
    logic cal_done_prev_reg;
    logic [10:0] run_cnt_reg;
    logic [10:0] run_cnt_next;
    logic pll_en_prev_reg;
    logic stable_prev_reg;
    spllc_timer_state_t state_reg;
    spllc_timer_state_t state_next;
    logic [19:0] remain_reg;
    logic [19:0] remain_next;
    logic [MSW-1:0] ms_div_reg;

    // ==================================================================
    // Synchronised pin inputs
    logic [2:0] pin_sync;

    spllc_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({vco_cal_done, pfd_in_phase, pfd_sample_toggle}),
        .sync_out(pin_sync)
    );

    // ==================================================================
    // Address decode
    wire wr_ctrl = reg_write && (reg_addr == `SPLLC_ADDR_CTRL);
    wire wr_cfg = reg_write && (reg_addr == `SPLLC_ADDR_CFG);
    wire wr_fbdiv = reg_write && (reg_addr == `SPLLC_ADDR_FBDIV);
    wire wr_per0 = reg_write && (reg_addr == `SPLLC_ADDR_PERIOD0);
    wire wr_per1 = reg_write && (reg_addr == `SPLLC_ADDR_PERIOD1);
    wire wr_per2 = reg_write && (reg_addr == `SPLLC_ADDR_PERIOD2);
    wire wr_tim0 = reg_write && (reg_addr == `SPLLC_ADDR_TIMER0);
    wire wr_tim1 = reg_write && (reg_addr == `SPLLC_ADDR_TIMER1);
    wire wr_tim2 = reg_write && (reg_addr == `SPLLC_ADDR_TIMER2);
    wire wr_mask = reg_write && (reg_addr == `SPLLC_ADDR_MASK);
    wire wr_cal = reg_write && (reg_addr == `SPLLC_ADDR_CAL);
    wire wr_mon = reg_write && (reg_addr == `SPLLC_ADDR_MONITOR);
    // Divide values below the minimum are refused so the loop never sees them.
    wire fbdiv_ok = (reg_wdata >= `SPLLC_FBDIV_MIN);

    // ==================================================================
    // Derived controls
    wire pfd_sample = pin_sync[0] ^ tick_prev_reg;
    wire in_phase = pin_sync[1];
    wire cal_done_evt = pin_sync[2] && !cal_done_prev_reg;
    wire lock_det_en = !ctrl_reg[`SPLLC_CTRL_LD_DISABLE];
    wire [10:0] lock_thresh = `SPLLC_LOCK_BASE << ctrl_reg[1:0];
    wire locked = lock_det_en && (run_cnt_reg > lock_thresh);
    wire cp_manual = ctrl_reg[`SPLLC_CTRL_CP_MANUAL];
    wire [2:0] cp_field = ctrl_reg[`SPLLC_CTRL_CP_HI:`SPLLC_CTRL_CP_LO];
    wire timer_zero = (timer_val_reg == 20'h00000);
    wire pll_en = cfg_reg[`SPLLC_CFG_PLL_ENABLE];
    wire restart = (pll_en != pll_en_prev_reg) || cal_start_reg;
    wire ms_tick = (ms_div_reg == MSW'(MS_CYCLES - 1));
    wire stable = (state_reg == SPLLC_ST_STABLE);
    wire stable_evt = stable && !stable_prev_reg;

    // Automatic current grows with the divide value, since loop gain falls as N rises.
    wire [2:0] cp_auto = (fbdiv_reg < 8'h20) ? 3'h1 :
                         (fbdiv_reg < 8'h40) ? 3'h3 :
                         (fbdiv_reg < 8'h80) ? 3'h5 : 3'h7;

    // ==================================================================
    // Configuration registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= `SPLLC_CTRL_RESET;
            cfg_reg <= `SPLLC_CFG_RESET;
            fbdiv_reg <= `SPLLC_FBDIV_RESET;
            mask_reg <= `SPLLC_MASK_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= reg_wdata;
            if (wr_cfg)
                cfg_reg <= {5'h00, reg_wdata[2:0]};
            if (wr_fbdiv && fbdiv_ok)
                fbdiv_reg <= reg_wdata;
            if (wr_mask)
                mask_reg <= reg_wdata;
        end
    end

    // Multi-byte values are written one byte at a time, low byte first.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            period_reg <= `SPLLC_PERIOD_RESET;
            timer_val_reg <= `SPLLC_TIMER_RESET;
        end
        else
        begin
            if (wr_per0)
                period_reg[7:0] <= reg_wdata;
            if (wr_per1)
                period_reg[15:8] <= reg_wdata;
            if (wr_per2)
                period_reg[20:16] <= reg_wdata[4:0];
            if (wr_tim0)
                timer_val_reg[7:0] <= reg_wdata;
            if (wr_tim1)
                timer_val_reg[15:8] <= reg_wdata;
            if (wr_tim2)
                timer_val_reg[19:16] <= reg_wdata[3:0];
        end
    end

    // ==================================================================
    // Calibration: launch on the falling edge of the calibrate bit.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cal_bit_reg <= 1'b0;
            cal_start_reg <= 1'b0;
            cal_busy_reg <= 1'b0;
            cal_done_prev_reg <= 1'b0;
        end
        else
        begin
            if (wr_cal)
                cal_bit_reg <= reg_wdata[`SPLLC_CAL_START];
            cal_start_reg <= wr_cal && cal_bit_reg && !reg_wdata[`SPLLC_CAL_START];
            cal_done_prev_reg <= pin_sync[2];
            if (cal_start_reg)
                cal_busy_reg <= 1'b1;
            else if (cal_done_evt)
                cal_busy_reg <= 1'b0;
        end
    end

    // ==================================================================
    // Lock detector run counter; it saturates just above the threshold.
    always_comb
    begin
        run_cnt_next = run_cnt_reg;
        if (!lock_det_en)
            run_cnt_next = 11'h000;
        else if (pfd_sample && !in_phase)
            run_cnt_next = 11'h000;
        else if (pfd_sample && !locked)
            run_cnt_next = run_cnt_reg + 11'h001;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_cnt_reg <= 11'h000;
            tick_prev_reg <= 1'b0;
        end
        else
        begin
            run_cnt_reg <= run_cnt_next;
            tick_prev_reg <= pin_sync[0];
        end
    end

    // ==================================================================
    // Stability timer. A restart comes from a PLL enable change or a calibration launch.
    always_comb
    begin
        state_next = state_reg;
        remain_next = remain_reg;
        if (restart)
        begin
            if (timer_zero)
                state_next = SPLLC_ST_STABLE;
            else if (!pll_en)
            begin
                state_next = SPLLC_ST_COUNT;
                remain_next = timer_val_reg;
            end
            else
                state_next = SPLLC_ST_WAIT_LOCK;
        end
        else
        begin
            case (state_reg)
                SPLLC_ST_WAIT_LOCK:
                begin
                    if (timer_zero)
                        state_next = SPLLC_ST_STABLE;
                    else if (locked || !pll_en)
                    begin
                        state_next = SPLLC_ST_COUNT;
                        remain_next = timer_val_reg;
                    end
                end
                SPLLC_ST_COUNT:
                begin
                    if (timer_zero)
                        state_next = SPLLC_ST_STABLE;
                    else if (pll_en && !locked)
                        state_next = SPLLC_ST_WAIT_LOCK;
                    else if (ms_tick && remain_reg <= 20'h00001)
                        state_next = SPLLC_ST_STABLE;
                    else if (ms_tick)
                        remain_next = remain_reg - 20'h00001;
                end
                SPLLC_ST_STABLE:
                    state_next = SPLLC_ST_STABLE;
                default:
                    state_next = SPLLC_ST_WAIT_LOCK;
            endcase
        end
    end

    // The millisecond divider only runs while counting, so a count entered from another state starts on a whole ms; a restart within COUNT keeps its phase.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= SPLLC_ST_WAIT_LOCK;
            remain_reg <= 20'h00000;
            ms_div_reg <= '0;
            pll_en_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            remain_reg <= remain_next;
            pll_en_prev_reg <= pll_en;
            if (state_next != SPLLC_ST_COUNT || state_reg != SPLLC_ST_COUNT || ms_tick)
                ms_div_reg <= '0;
            else
                ms_div_reg <= ms_div_reg + MSW'(1);
        end
    end

    // ==================================================================
    // Interrupt monitor: sticky, masked in, cleared by writing 1; a new event beats the clear.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            monitor_reg <= 8'h00;
            stable_prev_reg <= 1'b0;
        end
        else
        begin
            stable_prev_reg <= stable;
            if (wr_mon)
                monitor_reg <= monitor_reg & ~reg_wdata;
            if (cal_done_evt && mask_reg[`SPLLC_STAT_CAL_BUSY])
                monitor_reg[`SPLLC_STAT_CAL_BUSY] <= 1'b1;
            if (stable_evt && mask_reg[`SPLLC_STAT_STABLE])
                monitor_reg[`SPLLC_STAT_STABLE] <= 1'b1;
        end
    end

    // ==================================================================
    // Read mux; unmapped addresses read zero.
    wire [7:0] status_val = {3'h0, stable, 2'h0, cal_busy_reg, locked};
    wire [7:0] rd_mux =
        (reg_addr == `SPLLC_ADDR_CTRL) ? ctrl_reg :
        (reg_addr == `SPLLC_ADDR_CFG) ? cfg_reg :
        (reg_addr == `SPLLC_ADDR_FBDIV) ? fbdiv_reg :
        (reg_addr == `SPLLC_ADDR_PERIOD0) ? period_reg[7:0] :
        (reg_addr == `SPLLC_ADDR_PERIOD1) ? period_reg[15:8] :
        (reg_addr == `SPLLC_ADDR_PERIOD2) ? {3'h0, period_reg[20:16]} :
        (reg_addr == `SPLLC_ADDR_TIMER0) ? timer_val_reg[7:0] :
        (reg_addr == `SPLLC_ADDR_TIMER1) ? timer_val_reg[15:8] :
        (reg_addr == `SPLLC_ADDR_TIMER2) ? {4'h0, timer_val_reg[19:16]} :
        (reg_addr == `SPLLC_ADDR_MASK) ? mask_reg :
        (reg_addr == `SPLLC_ADDR_CAL) ? {7'h00, cal_bit_reg} :
        (reg_addr == `SPLLC_ADDR_STATUS) ? status_val :
        (reg_addr == `SPLLC_ADDR_MONITOR) ? monitor_reg : 8'h00;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_reg <= 8'h00;
        else if (reg_read)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 8'h00;
    end

    // ==================================================================
    // Outputs; all come from flip-flops or plain decodes of them.
    assign reg_rdata = rdata_reg;
    assign vco_cal_start = cal_start_reg;
    assign pll_enable = pll_en;
    assign input_div_sel = cfg_reg[2:1];
    assign feedback_div = fbdiv_reg;
    assign cp_current_code = cp_manual ? cp_field : cp_auto;
    assign ext_filter_sel = ctrl_reg[`SPLLC_CTRL_EXT_FILTER];
    assign clock_period_fs = period_reg;
    assign pll_locked = locked;
    assign clock_stable = stable;
    assign ref_monitor_enable = stable;
    assign irq_out = |monitor_reg;

endmodule : spllc_top

// [test/spllc_top_properties.sv]
// Concurrent checks on the ports of the PLL control block.
`timescale 1ns/1ps
`include "spllc_consts.svh"

module spllc_top_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    // Pins and settings
    input wire logic vco_cal_start,
    input wire logic pll_enable,
    input wire logic [1:0] input_div_sel,
    input wire logic [7:0] feedback_div,
    input wire logic [2:0] cp_current_code,
    input wire logic ext_filter_sel,
    input wire logic pll_locked,
    input wire logic clock_stable,
    input wire logic ref_monitor_enable
);
    // ==================================================================
    // Shadow copies of the written settings
    logic [7:0] ctrl_reg;
    logic [7:0] cfg_reg;
    logic cal_reg;
    logic cal_fall_reg;

    // Decodes of the writes that matter here.
    wire wr_ctrl = reg_write && (reg_addr == `SPLLC_ADDR_CTRL);
    wire wr_cfg = reg_write && (reg_addr == `SPLLC_ADDR_CFG);
    wire wr_cal = reg_write && (reg_addr == `SPLLC_ADDR_CAL);
    wire [2:0] auto_code = (feedback_div < 8'h20) ? 3'h1 : (feedback_div < 8'h40) ? 3'h3 :
        (feedback_div < 8'h80) ? 3'h5 : 3'h7;

    // The shadows update on the same edge as the design, so only lock_off_a allows for a cycle of lag.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= `SPLLC_CTRL_RESET;
            cfg_reg <= 8'h00;
            cal_reg <= 1'b0;
            cal_fall_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl) ctrl_reg <= reg_wdata;
            if (wr_cfg) cfg_reg <= reg_wdata;
            if (wr_cal) cal_reg <= reg_wdata[0];
            cal_fall_reg <= wr_cal && !reg_wdata[0] && cal_reg;
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    lock_off_a: assert property (ctrl_reg[2] && $past(ctrl_reg[2]) |-> !pll_locked)
        else $error("lock reported while detector disabled");
    cp_auto_a: assert property (!ctrl_reg[6] |-> cp_current_code == auto_code)
        else $error("automatic pump current wrong");
    cp_manual_a: assert property (ctrl_reg[6] |-> cp_current_code == ctrl_reg[5:3])
        else $error("manual pump current wrong");
    ext_filter_a: assert property (ext_filter_sel == ctrl_reg[7])
        else $error("filter select wrong");
    fbdiv_range_a: assert property (feedback_div >= `SPLLC_FBDIV_MIN)
        else $error("feedback divider below range");
    cfg_follow_a: assert property (pll_enable == cfg_reg[0] && input_div_sel == cfg_reg[2:1])
        else $error("enable or input divider wrong");
    cal_cause_a: assert property (vco_cal_start == cal_fall_reg)
        else $error("calibration start without falling bit");
    cal_pulse_a: assert property (vco_cal_start |=> !vco_cal_start)
        else $error("calibration start longer than a cycle");
    ref_gate_a: assert property (ref_monitor_enable == clock_stable)
        else $error("reference monitors enabled while not stable");

endmodule : spllc_top_properties

bind spllc_top spllc_top_properties u_props (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .vco_cal_start, .pll_enable,
    .input_div_sel, .feedback_div, .cp_current_code, .ext_filter_sel, .pll_locked,
    .clock_stable, .ref_monitor_enable
);

// [test/testbench.sv]
// Self-checking testbench for the PLL control block.
`timescale 1ns/1ps
`include "spllc_consts.svh"

module testbench;
    // ==================================================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic pfd_sample_toggle = 1'b0;
    logic pfd_in_phase = 1'b0;
    logic vco_cal_done = 1'b0;
    logic [7:0] reg_rdata, feedback_div, rd;
    logic [20:0] clock_period_fs;
    logic [2:0] cp_current_code;
    logic [1:0] input_div_sel;
    logic vco_cal_start, pll_enable, ext_filter_sel, pll_locked, clock_stable;
    logic ref_monitor_enable, irq_out;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int i;
    logic [7:0] fb_tab [4] = '{8'h06, 8'h3f, 8'h40, 8'hff};
    logic [2:0] cp_tab [4] = '{3'h1, 3'h3, 3'h5, 3'h7};

    // Clock at 40 MHz.
    always #12.5 core_clk = ~core_clk;

    // A small count per millisecond keeps the timer runs short.
    spllc_top #(.MS_CYCLES(4)) u_dut (
        .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .pfd_sample_toggle, .pfd_in_phase, .vco_cal_done, .vco_cal_start, .pll_enable,
        .input_div_sel, .feedback_div, .cp_current_code, .ext_filter_sel, .clock_period_fs,
        .pll_locked, .clock_stable, .ref_monitor_enable, .irq_out
    );

    // ==================================================================
    // Tasks
    task check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task stop_test;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // Waits whole cycles, then lets the edge's updates settle.
    task wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so it is taken there.
    task rdr(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rdr

    // Each level is held well over three cycles so the synchroniser sees it.
    task sample(input logic inph);
        @(posedge core_clk);
        pfd_in_phase <= inph;
        repeat (3) @(posedge core_clk);
        pfd_sample_toggle <= ~pfd_sample_toggle;
        wait_cyc(4);
    endtask : sample

    // A hang counts as a failure.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            stop_test;
        end
    end

    // ==================================================================
    // Test sequence
    initial
    begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        wait_cyc(2);
        check(clock_stable, 1'b1);
        check(ref_monitor_enable, 1'b1);
        check(cp_current_code, 3'h3);
        rdr(`SPLLC_ADDR_CTRL, rd);
        check(rd, 8'h18);
        wr(`SPLLC_ADDR_STATUS, 8'h00);
        rdr(`SPLLC_ADDR_STATUS, rd);
        check(rd, 8'h10);
        wr(`SPLLC_ADDR_PERIOD0, 8'h21);
        wr(`SPLLC_ADDR_PERIOD1, 8'h43);
        wr(`SPLLC_ADDR_PERIOD2, 8'hff);
        check(clock_period_fs, 21'h1f4321);
        // Only 20 timer bits exist; the top byte keeps four of them.
        wr(`SPLLC_ADDR_TIMER2, 8'hff);
        rdr(`SPLLC_ADDR_TIMER2, rd);
        check(rd, 8'h0f);
        wr(`SPLLC_ADDR_TIMER2, 8'h00);
        wr(16'h0200, 8'hff);
        rdr(16'h0200, rd);
        check(rd, 8'h00);
        wr(`SPLLC_ADDR_FBDIV, 8'h05);
        check(feedback_div, 8'h28);
        for (i = 0; i < 4; i++)
        begin
            wr(`SPLLC_ADDR_FBDIV, fb_tab[i]);
            check(feedback_div, fb_tab[i]);
            check(cp_current_code, cp_tab[i]);
        end
        wr(`SPLLC_ADDR_FBDIV, 8'h28);
        wr(`SPLLC_ADDR_CTRL, 8'h38);
        check(cp_current_code, 3'h3);
        for (i = 0; i < 8; i++)
        begin
            wr(`SPLLC_ADDR_CTRL, {i[0], 1'b1, i[2:0], 3'b000});
            check(cp_current_code, i[2:0]);
            check(ext_filter_sel, i[0]);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(`SPLLC_ADDR_CFG, {5'h00, i[1:0], 1'b0});
            check(input_div_sel, i[1:0]);
        end
        // A broken run must start over.
        wr(`SPLLC_ADDR_CTRL, 8'h18);
        repeat (100) sample(1'b1);
        sample(1'b0);
        repeat (128) sample(1'b1);
        check(pll_locked, 1'b0);
        sample(1'b1);
        check(pll_locked, 1'b1);
        rdr(`SPLLC_ADDR_STATUS, rd);
        check(rd[0], 1'b1);
        wr(`SPLLC_ADDR_CTRL, 8'h1c);
        check(pll_locked, 1'b0);
        wr(`SPLLC_ADDR_TIMER0, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            wr(`SPLLC_ADDR_CTRL, 8'h18 | i[7:0]);
            sample(1'b0);
            repeat (128 << i) sample(1'b1);
            check(pll_locked, 1'b0);
            sample(1'b1);
            check(pll_locked, 1'b1);
            sample(1'b0);
            check(pll_locked, 1'b0);
        end
        // Timer with the PLL enabled waits for lock.
        wr(`SPLLC_ADDR_CTRL, 8'h18);
        wr(`SPLLC_ADDR_MASK, 8'h12);
        wr(`SPLLC_ADDR_TIMER0, 8'h02);
        wr(`SPLLC_ADDR_CFG, 8'h01);
        check(pll_enable, 1'b1);
        wait_cyc(40);
        check(clock_stable, 1'b0);
        check(ref_monitor_enable, 1'b0);
        check(irq_out, 1'b0);
        repeat (129) sample(1'b1);
        wait_cyc(2);
        check(clock_stable, 1'b0);
        wait_cyc(12);
        check(clock_stable, 1'b1);
        check(irq_out, 1'b1);
        rdr(`SPLLC_ADDR_MONITOR, rd);
        check(rd, 8'h10);
        wr(`SPLLC_ADDR_MONITOR, 8'h10);
        check(irq_out, 1'b0);
        // Disabling the PLL starts the timer with no lock at all.
        sample(1'b0);
        wr(`SPLLC_ADDR_CFG, 8'h00);
        check(pll_enable, 1'b0);
        wait_cyc(3);
        check(clock_stable, 1'b0);
        wait_cyc(12);
        check(clock_stable, 1'b1);
        wr(`SPLLC_ADDR_MONITOR, 8'h12);
        // Calibration launches only on clearing the bit.
        wr(`SPLLC_ADDR_CAL, 8'h01);
        check(vco_cal_start, 1'b0);
        wr(`SPLLC_ADDR_CAL, 8'h01);
        check(vco_cal_start, 1'b0);
        wr(`SPLLC_ADDR_CAL, 8'h00);
        check(vco_cal_start, 1'b1);
        wait_cyc(1);
        check(vco_cal_start, 1'b0);
        rdr(`SPLLC_ADDR_STATUS, rd);
        check(rd[1], 1'b1);
        wr(`SPLLC_ADDR_CAL, 8'h00);
        check(vco_cal_start, 1'b0);
        @(posedge core_clk);
        vco_cal_done <= 1'b1;
        wait_cyc(6);
        rdr(`SPLLC_ADDR_STATUS, rd);
        check(rd[1], 1'b0);
        rdr(`SPLLC_ADDR_MONITOR, rd);
        check(rd[1], 1'b1);
        check(irq_out, 1'b1);
        stop_test;
    end

endmodule : testbench
